//--- verilog/cst_sequencer.sv
// Two-channel power sequencing timers on a shared open-drain timebase
// Overview of operation
// - Wait power-on delay before converter enable
// - Wait rise settle, then connect DAC
// - No UV threshold before timeout: fault
// - UV threshold reached in time: unmask UV
// - Zero power-up timeout disables the timeout
// - On, rise and timeout times count shared timebase ticks only
// - Off delay uses timebase, else internal oscillator
// - On/off delays clamped 13.1s, rounded
// - Rise and timeout clamped 655ms, 10us
// - Reads return exactly the written value
// - Control toggle restarts channels after hold
// - Long control off times stay unaltered
// - Zero restart hold disables the hold-off
// - Restart hold clamped 13.1s, 200us steps above 655ms
// - Timebase open-drain wired OR, falling edge
// - Vin share: hold timebase low when undervoltage
// - Timebase held low disables channels when Vin share on, deglitched
// - Timebase release starts a new sequence
// - Restart hold is one unpaged setting, 400ms
// - Defaults 1.0, 10.0 and 15.0 ms
`timescale 1ns/1ps
module cst_sequencer
   import cst_pkg::*;
#(
   parameter int NCH = 2
)(
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             shareClkIn,
   output logic                  shareClkOut,
   output logic                  shareClkOeN,
   input  wire logic             controlPin,
   input  wire logic [NCH-1:0]   opOn,
   input  wire logic [NCH-1:0]   uvAbove,
   input  wire logic [2*NCH-1:0] dacMode,
   input  wire logic             vinShareEn,
   input  wire logic             vinLow,
   input  wire cst_cmd_t         cmdReq,
   output cst_rsp_t              cmdRsp,
   output logic [NCH-1:0]        converterEnableOutput,
   output logic [NCH-1:0]        dacConnect,
   output logic [NCH-1:0]        powerUpTimeoutFault,
   output logic [NCH-1:0]        uvUnmask
);

   // Linear word to tick count with clamp and rounding
   function automatic logic [TCNT_W-1:0] toTicks(input logic [15:0] v, input logic wide);
      logic [4:0]  e;
      logic [4:0]  sh;
      logic [47:0] p;
      logic [47:0] r;
      e = v[L11_EXP_MSB:L11_EXP_LSB];
      sh = 5'(-e);
      p = v[L11_MANT_MSB] ? 48'h0 : 48'(v[L11_MANT_MSB-1:0]) * 48'(TICKS_PER_MS);
      if (!e[4])
         r = p << e;
      else
         r = (p + (48'h1 << (sh - 5'h1))) >> sh;
      if (wide)
      begin
         if (r > LONG_MAX_TICKS)
            r = LONG_MAX_TICKS;
         if (r > SHORT_MAX_TICKS)
            r = ((r + LONG_RES_TICKS / 48'h2) / LONG_RES_TICKS) * LONG_RES_TICKS;
         if (r > LONG_MAX_TICKS)
            r = LONG_MAX_TICKS;
      end
      else if (r > SHORT_MAX_TICKS)
         r = SHORT_MAX_TICKS;
      return r[TCNT_W-1:0];
   endfunction

   // Raw register storage, read back untouched
   logic [15:0] ponRaw_q   [NCH];
   logic [15:0] riseRaw_q  [NCH];
   logic [15:0] pupRaw_q   [NCH];
   logic [15:0] poffRaw_q  [NCH];
   logic [15:0] restartRaw_q;
   cst_rsp_t    rsp_q;
   logic        hit;
   logic [15:0] rdMux;

   // Command decode and read mux
   always_comb
   begin
      hit = 1'b1;
      rdMux = 16'h0000;
      unique case (cmdReq.code)
         CMD_PON_DELAY:   rdMux = ponRaw_q[cmdReq.page];
         CMD_RISE_SETTLE: rdMux = riseRaw_q[cmdReq.page];
         CMD_PUP_TIMEOUT: rdMux = pupRaw_q[cmdReq.page];
         CMD_POFF_DELAY:  rdMux = poffRaw_q[cmdReq.page];
         CMD_RESTART:     rdMux = restartRaw_q;
         default:         hit = 1'b0;
      endcase
   end

   // Register writes, paged per channel except the unpaged restart hold
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            ponRaw_q[i]  <= RST_PON_DELAY;
            riseRaw_q[i] <= RST_RISE_SETTLE;
            pupRaw_q[i]  <= RST_PUP_TIMEOUT;
            poffRaw_q[i] <= RST_POFF_DELAY;
         end
         restartRaw_q <= RST_RESTART;
      end
      else if (cmdReq.wrEn)
      begin
         if (cmdReq.code == CMD_PON_DELAY)
            ponRaw_q[cmdReq.page] <= cmdReq.wdata;
         if (cmdReq.code == CMD_RISE_SETTLE)
            riseRaw_q[cmdReq.page] <= cmdReq.wdata;
         if (cmdReq.code == CMD_PUP_TIMEOUT)
            pupRaw_q[cmdReq.page] <= cmdReq.wdata;
         if (cmdReq.code == CMD_POFF_DELAY)
            poffRaw_q[cmdReq.page] <= cmdReq.wdata;
         if (cmdReq.code == CMD_RESTART)
            restartRaw_q <= cmdReq.wdata;
      end
   end

   // Registered answer, one cycle after the request
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         rsp_q <= '0;
      else
      begin
         rsp_q.valid <= cmdReq.rdEn | cmdReq.wrEn;
         rsp_q.ack   <= (cmdReq.rdEn | cmdReq.wrEn) & hit;
         rsp_q.rdata <= (cmdReq.rdEn & hit) ? rdMux : 16'h0000;
      end
   end
   assign cmdRsp = rsp_q;

   // Falling edges of the shared line toggle a flag in the link domain
   logic linkTgl_q;
   always_ff @(negedge shareClkIn or posedge rst)
   begin
      if (rst)
         linkTgl_q <= 1'b0;
      else
         linkTgl_q <= ~linkTgl_q;
   end

   // Synchronisers into the system domain
   logic [2:0] tglSync_q;
   logic [1:0] lineSync_q;
   logic [1:0] ctrlSync_q;
   logic [1:0] uvSync_q [NCH];
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         tglSync_q  <= 3'h0;
         lineSync_q <= 2'h3;
         ctrlSync_q <= 2'h0;
         for (int i = 0; i < NCH; i++)
            uvSync_q[i] <= 2'h0;
      end
      else
      begin
         tglSync_q  <= {tglSync_q[1:0], linkTgl_q};
         lineSync_q <= {lineSync_q[0], shareClkIn};
         ctrlSync_q <= {ctrlSync_q[0], controlPin};
         for (int i = 0; i < NCH; i++)
            uvSync_q[i] <= {uvSync_q[i][0], uvAbove[i]};
      end
   end
   logic linkTick;
   assign linkTick = tglSync_q[2] ^ tglSync_q[1];

   // Internal oscillator, drives the shared line as an open-drain clock
   logic [10:0] oscCnt_q;
   logic        oscTick_q;
   logic        drvLow_q;
   logic        vinHold;
   assign vinHold = vinShareEn & vinLow;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         oscCnt_q  <= 11'h000;
         oscTick_q <= 1'b0;
         drvLow_q  <= 1'b0;
      end
      else
      begin
         oscTick_q <= (oscCnt_q == 11'(OSC_TICK_CYC - 1));
         oscCnt_q  <= (oscCnt_q == 11'(OSC_TICK_CYC - 1)) ? 11'h000 : oscCnt_q + 11'h001;
         drvLow_q  <= vinHold | (oscCnt_q < 11'(OSC_TICK_CYC / 2));
      end
   end
   assign shareClkOut = 1'b0;
   assign shareClkOeN = ~drvLow_q;

   // Timebase presence and fallback for the off delay
   logic [11:0] lossCnt_q;
   logic        linkOk_q;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         lossCnt_q <= 12'h000;
         linkOk_q  <= 1'b0;
      end
      else
      begin
         if (linkTick)
            lossCnt_q <= 12'h000;
         else if (lossCnt_q != 12'(LINK_LOSS_CYC))
            lossCnt_q <= lossCnt_q + 12'h001;
         linkOk_q <= (lossCnt_q != 12'(LINK_LOSS_CYC));
      end
   end
   logic offTick;
   assign offTick = linkOk_q ? linkTick : oscTick_q;

   // Shared line held low with Vin share on: deglitched channel shutdown, release restarts
   logic [11:0] lowCnt_q;
   logic        vinOff_q;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         lowCnt_q <= 12'h000;
         vinOff_q <= 1'b0;
      end
      else
      begin
         if (lineSync_q[1])
            lowCnt_q <= 12'h000;
         else if (lowCnt_q != 12'(VIN_DEGLITCH_CYC))
            lowCnt_q <= lowCnt_q + 12'h001;
         if (!vinShareEn)
            vinOff_q <= 1'b0;
         else if (lowCnt_q == 12'(VIN_DEGLITCH_CYC))
            vinOff_q <= 1'b1;
         else if (lineSync_q[1])
            vinOff_q <= 1'b0;
      end
   end

   // Restart hold-off after a short control off pulse
   logic [TCNT_W-1:0] restartTicks;
   logic [10:0]       offCyc_q;
   logic [TCNT_W-1:0] offTicks_q;
   logic [TCNT_W-1:0] holdCnt_q;
   logic              hold_q;
   logic              ctrlPrev_q;
   assign restartTicks = toTicks(restartRaw_q, 1'b1);
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         offCyc_q   <= 11'h000;
         offTicks_q <= '0;
         holdCnt_q  <= '0;
         hold_q     <= 1'b0;
         ctrlPrev_q <= 1'b0;
      end
      else
      begin
         ctrlPrev_q <= ctrlSync_q[1];
         if (ctrlSync_q[1])
         begin
            offCyc_q   <= 11'h000;
            offTicks_q <= '0;
         end
         else
         begin
            if (offCyc_q != 11'(CTRL_MIN_OFF_CYC))
               offCyc_q <= offCyc_q + 11'h001;
            if (linkTick && offTicks_q != '1)
               offTicks_q <= offTicks_q + 1'b1;
         end
         if (ctrlSync_q[1] && !ctrlPrev_q && offCyc_q == 11'(CTRL_MIN_OFF_CYC)
             && restartTicks != '0
             && offTicks_q < restartTicks)
         begin
            hold_q    <= 1'b1;
            holdCnt_q <= '0;
         end
         else if (hold_q)
         begin
            if (!ctrlSync_q[1] || holdCnt_q >= restartTicks)
               hold_q <= 1'b0;
            else if (linkTick)
               holdCnt_q <= holdCnt_q + 1'b1;
         end
      end
   end

   // Per-channel sequencing machines
   for (genvar ch = 0; ch < NCH; ch++)
   begin : g_ch
      cst_state_t        state_q;
      logic [TCNT_W-1:0] cnt_q;
      logic [TCNT_W-1:0] maxCnt_q;
      logic [TCNT_W-1:0] ponTicks;
      logic [TCNT_W-1:0] riseTicks;
      logic [TCNT_W-1:0] pupTicks;
      logic [TCNT_W-1:0] poffTicks;
      logic              run;
      logic              kill;
      logic              enOut_q;
      logic              dacOut_q;
      logic              fault_q;
      logic              unmask_q;

      assign ponTicks  = toTicks(ponRaw_q[ch], 1'b1);
      assign poffTicks = toTicks(poffRaw_q[ch], 1'b1);
      assign riseTicks = toTicks(riseRaw_q[ch], 1'b0);
      assign pupTicks  = toTicks(pupRaw_q[ch], 1'b0);
      assign run  = opOn[ch] & ctrlSync_q[1];
      assign kill = hold_q | vinOff_q;

      // State and delay counter
      always_ff @(posedge sys_clk or posedge rst)
      begin
         if (rst)
         begin
            state_q  <= ST_OFF;
            cnt_q    <= '0;
            enOut_q  <= 1'b0;
            dacOut_q <= 1'b0;
         end
         else if (kill)
         begin
            state_q  <= ST_OFF;
            cnt_q    <= '0;
            enOut_q  <= 1'b0;
            dacOut_q <= 1'b0;
         end
         else
         begin
            unique case (state_q)
               ST_OFF:
               begin
                  cnt_q <= '0;
                  if (run)
                     state_q <= ST_ONDLY;
               end
               ST_ONDLY:
               begin
                  if (!run)
                     state_q <= ST_OFF;
                  else if (cnt_q >= ponTicks)
                  begin
                     enOut_q <= 1'b1;
                     cnt_q   <= '0;
                     state_q <= ST_RISE;
                  end
                  else if (linkTick)
                     cnt_q <= cnt_q + 1'b1;
               end
               ST_RISE:
               begin
                  if (!run)
                  begin
                     cnt_q   <= '0;
                     state_q <= ST_OFFDLY;
                  end
                  else if (cnt_q >= riseTicks)
                  begin
                     dacOut_q <= (dacMode[2*ch +: 2] == DAC_MODE_SOFT);
                     state_q  <= ST_ON;
                  end
                  else if (linkTick)
                     cnt_q <= cnt_q + 1'b1;
               end
               ST_ON:
               begin
                  cnt_q <= '0;
                  if (!run)
                     state_q <= ST_OFFDLY;
               end
               ST_OFFDLY:
               begin
                  if (cnt_q >= poffTicks)
                  begin
                     enOut_q  <= 1'b0;
                     dacOut_q <= 1'b0;
                     state_q  <= ST_OFF;
                  end
                  else if (offTick)
                     cnt_q <= cnt_q + 1'b1;
               end
               default:
                  state_q <= ST_OFF;
            endcase
         end
      end

      // Power-up timeout and undervoltage unmask
      always_ff @(posedge sys_clk or posedge rst)
      begin
         if (rst)
         begin
            maxCnt_q <= '0;
            fault_q  <= 1'b0;
            unmask_q <= 1'b0;
         end
         else if (!enOut_q)
         begin
            maxCnt_q <= '0;
            unmask_q <= 1'b0;
            if (state_q == ST_ONDLY)
               fault_q <= 1'b0;
         end
         else if (!unmask_q && !fault_q)
         begin
            if (uvSync_q[ch][1])
               unmask_q <= 1'b1;
            else if (pupTicks != '0 && maxCnt_q >= pupTicks)
               fault_q <= 1'b1;
            else if (linkTick && maxCnt_q != '1)
               maxCnt_q <= maxCnt_q + 1'b1;
         end
      end

      assign converterEnableOutput[ch] = enOut_q;
      assign dacConnect[ch]            = dacOut_q;
      assign powerUpTimeoutFault[ch]   = fault_q;
      assign uvUnmask[ch]              = unmask_q;
   end

endmodule // cst_sequencer

//--- verilog/cst_pkg.sv
// Constants, types and register map of the channel sequence timers
package cst_pkg;
   // Clock and timing base
   localparam int SYS_CLK_MHZ      = 125;
   localparam int TICK_US          = 10;     // One timebase tick, microseconds
   localparam int OSC_TICK_CYC     = TICK_US * SYS_CLK_MHZ;
   localparam int CTRL_MIN_OFF_US  = 10;
   localparam int CTRL_MIN_OFF_CYC = CTRL_MIN_OFF_US * SYS_CLK_MHZ;
   localparam int VIN_DEGLITCH_US  = 20;
   localparam int VIN_DEGLITCH_CYC = VIN_DEGLITCH_US * SYS_CLK_MHZ;
   localparam int LINK_LOSS_CYC    = 2 * OSC_TICK_CYC;
   localparam int TICKS_PER_MS     = 1000 / TICK_US;
   // Clamp and rounding limits in ticks
   localparam int LONG_MAX_MS      = 13100;  // 13.1 s
   localparam int SHORT_MAX_MS     = 655;
   localparam int LONG_RES_US      = 200;
   localparam logic [47:0] LONG_MAX_TICKS  = 48'(LONG_MAX_MS * TICKS_PER_MS);
   localparam logic [47:0] SHORT_MAX_TICKS = 48'(SHORT_MAX_MS * TICKS_PER_MS);
   localparam logic [47:0] LONG_RES_TICKS  = 48'(LONG_RES_US / TICK_US);
   localparam int TCNT_W           = 21;
   // Register command codes
   localparam logic [7:0] CMD_PON_DELAY   = 8'h60;
   localparam logic [7:0] CMD_RISE_SETTLE = 8'h61;
   localparam logic [7:0] CMD_PUP_TIMEOUT = 8'h62;
   localparam logic [7:0] CMD_POFF_DELAY  = 8'h64;
   localparam logic [7:0] CMD_RESTART     = 8'hDC;
   // Reset values
   localparam logic [15:0] RST_PON_DELAY   = 16'hBA00;
   localparam logic [15:0] RST_RISE_SETTLE = 16'hD280;
   localparam logic [15:0] RST_PUP_TIMEOUT = 16'hD3C0;
   localparam logic [15:0] RST_POFF_DELAY  = 16'hBA00;
   localparam logic [15:0] RST_RESTART     = 16'hFB20;
   // Linear format fields
   localparam int L11_EXP_MSB  = 15;
   localparam int L11_EXP_LSB  = 11;
   localparam int L11_MANT_MSB = 10;
   localparam logic [1:0] DAC_MODE_SOFT = 2'h0;

   typedef enum logic [2:0] {
      ST_OFF    = 3'h0,
      ST_ONDLY  = 3'h1,
      ST_RISE   = 3'h2,
      ST_ON     = 3'h3,
      ST_OFFDLY = 3'h4
   } cst_state_t;

   // Register command request
   typedef struct packed {
      logic        wrEn;
      logic        rdEn;
      logic        page;
      logic [7:0]  code;
      logic [15:0] wdata;
   } cst_cmd_t;

   // Register command answer
   typedef struct packed {
      logic        valid;
      logic        ack;
      logic [15:0] rdata;
   } cst_rsp_t;
endpackage

//--- verification/cst_peer_model.sv
// Peer power manager sharing the open-drain timebase line
`timescale 1ns/1ps
module cst_peer_model (
   input  wire logic run,
   input  wire logic holdLow,
   input  wire logic dutOeN,
   output logic      lineLvl
);
   logic phase = 1'b1;

   // Peer clock of 32 ns, phase unrelated to the system clock
   initial
   begin
      #5;
      forever #16 phase = ~phase;
   end

   // Wired OR with pull-up: any party pulling low wins
   assign lineLvl = dutOeN & ~holdLow & ~(run & ~phase);
endmodule // cst_peer_model

//--- verification/cst_sequencer_asserts.sv
// Port assertions for the channel sequence timers
`timescale 1ns/1ps
module cst_sequencer_asserts
   import cst_pkg::*;
#(
   parameter int NCH = 2
)(
   input wire logic             sys_clk,
   input wire logic             rst,
   input wire logic             shareClkIn,
   input wire logic             shareClkOut,
   input wire logic             shareClkOeN,
   input wire logic             controlPin,
   input wire logic [NCH-1:0]   opOn,
   input wire logic [NCH-1:0]   uvAbove,
   input wire logic [2*NCH-1:0] dacMode,
   input wire logic             vinShareEn,
   input wire logic             vinLow,
   input wire cst_cmd_t         cmdReq,
   input wire cst_rsp_t         cmdRsp,
   input wire logic [NCH-1:0]   converterEnableOutput,
   input wire logic [NCH-1:0]   dacConnect,
   input wire logic [NCH-1:0]   powerUpTimeoutFault,
   input wire logic [NCH-1:0]   uvUnmask
);
   logic [9:0] lowCnt_q;
   logic       knownCode;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Length of the self-driven low phase of the timebase
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst || shareClkOeN || (vinShareEn && vinLow))
         lowCnt_q <= 10'h000;
      else
         lowCnt_q <= lowCnt_q + 10'h001;
   end

   // Codes that the register port accepts
   assign knownCode = cmdReq.code inside {CMD_PON_DELAY, CMD_RISE_SETTLE,
                                          CMD_PUP_TIMEOUT, CMD_POFF_DELAY, CMD_RESTART};

   sequence sVinHold;
      vinShareEn && vinLow ##1 vinShareEn && vinLow;
   endsequence

   a_vin_hold_low: assert property (sVinHold |-> !shareClkOeN)
      else $error("timebase not held low in undervoltage");
   a_drive_zero: assert property (shareClkOut == 1'b0)
      else $error("timebase drive value not low");
   a_osc_low_len: assert property (lowCnt_q <= 10'h272)
      else $error("own timebase low phase too long");
   a_rsp_follows: assert property (cmdRsp.valid == $past(cmdReq.wrEn || cmdReq.rdEn))
      else $error("answer not one cycle after request");
   a_ack_codes: assert property (cmdRsp.valid |-> cmdRsp.ack == $past(knownCode))
      else $error("acknowledge does not match code");
   a_refused_zero: assert property (cmdRsp.valid && !cmdRsp.ack |-> cmdRsp.rdata == 16'h0000)
      else $error("refused read returned data");
   a_dac_after_en: assert property ($rose(dacConnect[0]) |->
      converterEnableOutput[0] && $past(converterEnableOutput[0], 2))
      else $error("dac connected without settled enable");
   a_dac_mode_gate: assert property ($rose(dacConnect[0]) |-> dacMode[1:0] == DAC_MODE_SOFT)
      else $error("dac connected in other mode");
   a_unmask_cause: assert property ($rose(uvUnmask[0]) |->
      uvAbove[0] && converterEnableOutput[0])
      else $error("undervoltage unmasked without cause");
   a_fault_cause: assert property ($rose(powerUpTimeoutFault[0]) |->
      $past(converterEnableOutput[0]) && !uvUnmask[0])
      else $error("timeout fault without enabled channel");
endmodule // cst_sequencer_asserts

bind cst_sequencer cst_sequencer_asserts #(.NCH(NCH)) u_asserts (
   .sys_clk(sys_clk), .rst(rst), .shareClkIn(shareClkIn), .shareClkOut(shareClkOut),
   .shareClkOeN(shareClkOeN), .controlPin(controlPin), .opOn(opOn), .uvAbove(uvAbove),
   .dacMode(dacMode), .vinShareEn(vinShareEn), .vinLow(vinLow), .cmdReq(cmdReq),
   .cmdRsp(cmdRsp), .converterEnableOutput(converterEnableOutput),
   .dacConnect(dacConnect), .powerUpTimeoutFault(powerUpTimeoutFault),
   .uvUnmask(uvUnmask));

//--- verification/channel_sequence_timers_tb.sv
// Self-checking bench for the channel sequence timers
`timescale 1ns/1ps
module channel_sequence_timers_tb
   import cst_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        controlPin = 1'b0;
   logic [1:0]  opOn = 2'b00;
   logic [1:0]  uvAbove = 2'b00;
   logic [3:0]  dacMode = 4'h4;
   logic        vinShareEn = 1'b0;
   logic        vinLow = 1'b0;
   logic        run = 1'b0;
   logic        holdLow = 1'b0;
   logic        shareClkOut, shareClkOeN, lineLvl;
   cst_cmd_t    cmdReq = '0;
   cst_rsp_t    cmdRsp;
   logic [1:0]  en, dac, fault, unmask;
   logic [7:0]  outs;
   logic [7:0]  codes [5] = '{8'h60, 8'h61, 8'h62, 8'h64, 8'hDC};
   logic [15:0] rsts [5] = '{16'hBA00, 16'hD280, 16'hD3C0, 16'hBA00, 16'hFB20};
   int          err_count = 0;
   int          checked = 0;
   int          cyc = 0;
   int          n;

   assign outs = {unmask, fault, dac, en};

   cst_sequencer #(.NCH(2)) dut (
      .sys_clk(sys_clk), .rst(rst), .shareClkIn(lineLvl), .shareClkOut(shareClkOut),
      .shareClkOeN(shareClkOeN), .controlPin(controlPin), .opOn(opOn), .uvAbove(uvAbove),
      .dacMode(dacMode), .vinShareEn(vinShareEn), .vinLow(vinLow), .cmdReq(cmdReq),
      .cmdRsp(cmdRsp), .converterEnableOutput(en), .dacConnect(dac),
      .powerUpTimeoutFault(fault), .uvUnmask(unmask));

   cst_peer_model peer (.run(run), .holdLow(holdLow), .dutOeN(shareClkOeN), .lineLvl(lineLvl));

   // System clock, 8 ns
   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop;
      $display("compares %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 70000)
      begin
         err_count++;
         report_and_stop;
      end
   end

   task automatic chkBit(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: level %b, want %b", $time, got, exp);
      end
   endtask

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: data %h, want %h", $time, got, exp);
      end
   endtask

   task automatic chkMin(input int got, input int lo);
      checked++;
      if (got < lo)
      begin
         err_count++;
         $display("unexpected at %0t: %0d cycles, want %0d or more", $time, got, lo);
      end
   endtask

   task automatic cycles(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask

   // Waits for output k to reach v, bounded, then compares it
   task automatic waitSel(input int k, input logic v, input int lim, output int c);
      c = 0;
      while (outs[k] !== v && c < lim)
      begin
         cycles(1);
         c++;
      end
      chkBit(outs[k], v);
   endtask

   // One register transfer, held over the edge that takes it
   task automatic xfer(input logic wr, input logic [7:0] code, input logic pg,
                       input logic [15:0] wd, output cst_rsp_t r);
      cmdReq = '{wrEn: wr, rdEn: !wr, page: pg, code: code, wdata: wd};
      cycles(1);
      r = cmdRsp;
      cmdReq = '0;
      cycles(1);                                          // Idle edge between transfers
      chkBit(r.valid, 1'b1);
   endtask

   task automatic rd(input logic [7:0] c, input logic pg, input logic [15:0] e, input logic a);
      cst_rsp_t r;
      xfer(1'b0, c, pg, 16'h0000, r);
      chkBit(r.ack, a);
      chk16(r.rdata, e);
   endtask

   task automatic wr(input logic [7:0] c, input logic pg, input logic [15:0] d);
      cst_rsp_t r;
      xfer(1'b1, c, pg, d, r);
      chkBit(r.ack, 1'b1);
   endtask

   initial
   begin
      cycles(2);
      rst = 1'b0;
      // Reset values on both pages, refused code, exact readback
      for (int i = 0; i < 5; i++)
      begin
         rd(codes[i], 1'b0, rsts[i], 1'b1);
         rd(codes[i], 1'b1, rsts[i], 1'b1);
      end
      rd(8'h63, 1'b0, 16'h0000, 1'b0);
      wr(8'h60, 1'b1, 16'h7FFF);
      rd(8'h60, 1'b1, 16'h7FFF, 1'b1);
      rd(8'h60, 1'b0, 16'hBA00, 1'b1);
      wr(8'h60, 1'b1, 16'hBA00);
      wr(8'h61, 1'b1, 16'h7BFF);
      rd(8'h61, 1'b1, 16'h7BFF, 1'b1);
      wr(8'h62, 1'b1, 16'h0000);
      wr(8'hDC, 1'b1, 16'hBA00);
      rd(8'hDC, 1'b0, 16'hBA00, 1'b1);
      // Both channels start on the running link
      run = 1'b1;
      uvAbove = 2'b01;
      controlPin = 1'b1;
      opOn = 2'b11;
      waitSel(0, 1'b1, 4000, n);
      chkMin(n, 390);
      waitSel(2, 1'b1, 12000, n);
      chkMin(n, 3990);
      chkBit(dac[1], 1'b0);
      waitSel(6, 1'b1, 4000, n);
      // Off delay, then a start frozen while the line is held low
      opOn[0] = 1'b0;
      waitSel(0, 1'b0, 4000, n);
      chkMin(n, 390);
      holdLow = 1'b1;
      uvAbove[0] = 1'b0;
      opOn[0] = 1'b1;
      cycles(3000);
      chkBit(en[0], 1'b0);
      holdLow = 1'b0;
      waitSel(0, 1'b1, 4000, n);
      chkMin(n, 390);
      waitSel(4, 1'b1, 16000, n);
      chkMin(n, 5990);
      chkBit(unmask[0], 1'b0);
      chkBit(fault[1], 1'b0);
      // Short off delay counted without the peer clock
      wr(8'h64, 1'b0, 16'hB014);
      run = 1'b0;
      opOn[0] = 1'b0;
      waitSel(0, 1'b0, 8000, n);
      chkMin(n, 1000);
      // Input undervoltage shared on the line
      run = 1'b1;
      vinShareEn = 1'b1;
      vinLow = 1'b1;
      waitSel(1, 1'b0, 4000, n);
      chkMin(n, 2400);
      chkBit(lineLvl, 1'b0);
      vinLow = 1'b0;
      waitSel(1, 1'b1, 6000, n);
      chkMin(n, 390);
      vinShareEn = 1'b0;
      // Short control toggle: hold-off, then a new start
      run = 1'b0;
      controlPin = 1'b0;
      cycles(1500);
      chkBit(en[1], 1'b1);
      controlPin = 1'b1;
      waitSel(1, 1'b0, 20, n);
      run = 1'b1;
      waitSel(1, 1'b1, 8000, n);
      chkMin(n, 790);
      // Zero hold time: the same toggle leaves the channel on
      wr(8'hDC, 1'b0, 16'h0000);
      run = 1'b0;
      controlPin = 1'b0;
      cycles(1500);
      controlPin = 1'b1;
      cycles(100);
      chkBit(en[1], 1'b1);
      report_and_stop;
   end
endmodule // channel_sequence_timers_tb
